// File: src/achpd_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module achpd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse depths that the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_check
    $error("achpd_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } achpd_fifo_state_t;

  achpd_fifo_state_t st_reg;
  achpd_fifo_state_t st_next;
  logic push;
  logic pop;

  // Full and empty straight from the fill count
  assign in_ready = (st_reg.cnt != (PW + 1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and storage update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : achpd_fifo
`default_nettype wire

// File: src/achpd_pkg.sv
// Shared constants and types of the ATA card host port decoder
package achpd_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  // Plain default for the reset initialisation sequence length
  localparam int INIT_TIME_NS = 2000;
  localparam int INIT_CYCLES =
    (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Widths and buffering
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 11;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Command and control block offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_ERR_FEAT = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_SECTOR = 3'h3;
  localparam logic [2:0] OFS_CYL_LO = 3'h4;
  localparam logic [2:0] OFS_CYL_HI = 3'h5;
  localparam logic [2:0] OFS_DRV_HEAD = 3'h6;
  localparam logic [2:0] OFS_STAT_CMD = 3'h7;
  localparam logic [2:0] CTL_ALT_DEVCTL = 3'h6;
  localparam logic [2:0] CTL_DRV_ADDR = 3'h7;

  // Sixteen-byte window offsets beyond the command block
  localparam logic [3:0] IX_DATA_LO = 4'h8;
  localparam logic [3:0] IX_DATA_HI = 4'h9;
  localparam logic [3:0] IX_ERR_DUP = 4'hD;
  localparam logic [3:0] IX_ALT = 4'hE;
  localparam logic [3:0] IX_DRV_ADDR = 4'hF;

  // ----------------------------------------------------------------
  // Address decode constants
  // ----------------------------------------------------------------
  localparam int MEM_DATA_BIT = 10;
  localparam logic [9:0] PRI_CMD_BASE = 10'h1F0;
  localparam logic [9:0] PRI_CTL_BASE = 10'h3F6;
  localparam logic [9:0] SEC_CMD_BASE = 10'h170;
  localparam logic [9:0] SEC_CTL_BASE = 10'h376;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NIEN_POS = 1;
  localparam int DRV_POS = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_MEMORY = 2'h0,
    CFG_INDEP_IO = 2'h1,
    CFG_PRIMARY = 2'h2,
    CFG_SECONDARY = 2'h3
  } achpd_cfg_t;

  typedef enum logic [2:0] {
    DUP_NONE = 3'b001,
    DUP_LOW = 3'b010,
    DUP_HIGH = 3'b100
  } achpd_dup_t;

  typedef struct packed {
    logic valid;
    logic ctl;
    logic [2:0] ofs;
    achpd_dup_t dup;
  } achpd_target_t;

endpackage : achpd_pkg

// File: src/achpd_top.sv
// Host port decoder of a dual-personality solid-state ATA drive
//
// Contract
// - Sample mode-detect at reset; grounded selects IDE, otherwise PC card.
// - Reset pin clears all registers (write FIFO not cleared, only rst resets it); active high PC card, active low IDE.
// - IDE interrupt is inverted PC-card request; IDE reset is inverted too.
// - IDE interrupt floats unless interrupts enabled and this drive selected.
// - Interrupt set by controller; cleared by status read or command write.
// - PC-card ready/busy shows internal activity; high only when accepting.
// - PC-card write-protect pin low once reset initialisation completes.
// - IDE word-transfer pin asserted, three-state, on data register access.
// - PC card decodes A0-10 by mode, ignores higher; IDE uses A0-2.
// - Even enable serves low lane, odd enable high lane; both for words.
// - Register select high means common memory, low means registers.
// - Wait held low while a cycle cannot yet complete.
// - Input acknowledge low while answering a selected I/O read.
// - IDE data driven during read strobe; writes captured at strobe rise.
// - Status-change pin signals ready/busy or write-protect changes.
// - IDE open-drain drive-active pulled low while the drive is accessed.
// - Control block: 6 alt status/device control, 7 drive address, 0-5 bad.
// - Independent I/O: 8,9 duplicate data, D duplicates error; A-C invalid.
// - Data auto-increments per access; 8 low of X, 9 high of X+1.
// - Host places drive on 16-byte boundary; drive decodes A0-3 only.
`timescale 1ns/1ps
`default_nettype none
module achpd_top #(
  parameter int INIT_CYCLES = achpd_pkg::INIT_CYCLES,
  parameter int FIFO_DEPTH = achpd_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic personality_detect_n,
  input wire logic host_reset_pin,
  input wire logic even_enable_n,
  input wire logic odd_enable_n,
  input wire logic reg_select_n,
  input wire logic out_enable_n,
  input wire logic wr_enable_n,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic [achpd_pkg::ADDR_W-1:0] addr,
  input wire logic [achpd_pkg::DATA_W-1:0] data_in,
  output logic [achpd_pkg::DATA_W-1:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic ready_irq_out,
  output logic ready_irq_oe,
  output logic wait_n,
  output logic inpack_n,
  output logic word_io_out,
  output logic word_io_oe,
  output logic status_change_n,
  output logic drive_active_n,
  output logic drive_active_oe,
  input wire logic [1:0] pc_config,
  input wire logic drive_unit,
  input wire logic ctrl_irq,
  input wire logic ctrl_busy,
  input wire logic [7:0] error_code_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] drive_addr_in,
  input wire logic [achpd_pkg::DATA_W-1:0] rd_word,
  input wire logic rd_valid,
  output logic rd_pop,
  output logic [achpd_pkg::DATA_W-1:0] wr_word,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] feature_select,
  output logic [7:0] transfer_sector_count,
  output logic [7:0] start_sector_number,
  output logic [7:0] cylinder_low_byte,
  output logic [7:0] cylinder_high_byte,
  output logic [7:0] drive_head_select,
  output logic [7:0] device_control,
  output logic [7:0] command_issue,
  output logic command_strobe
);
  localparam int IW = $clog2(INIT_CYCLES + 1);

  // Refuse values the counters cannot serve
  if (INIT_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_check
    $error("achpd_top: INIT_CYCLES >= 1 and FIFO_DEPTH >= 2 required");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mode_taken;
    logic ide_mode;
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_head;
    logic [7:0] dev_ctrl;
    logic [7:0] command;
    logic cmd_pulse;
    logic irq;
    logic act;
    logic act_wr;
    achpd_pkg::achpd_target_t act_tgt;
    logic act_lo;
    logic [15:0] act_data;
    logic [7:0] lo_hold;
    logic [15:0] push_word;
    logic push;
    logic pop;
    logic [15:0] dout;
    logic oe_lo;
    logic oe_hi;
    logic [IW-1:0] init_cnt;
    logic init_done;
    logic rdy_prev;
    logic wp_prev;
    logic stschg;
  } achpd_state_t;

  achpd_state_t st_reg;
  achpd_state_t st_next;

  achpd_pkg::achpd_target_t tgt;
  logic rd_now;
  logic wr_now;
  logic enabled;
  logic access;
  logic data_tgt;
  logic lane_lo;
  logic lane_hi;
  logic io_cfg;
  logic pin_rst;
  logic rdy;
  logic [7:0] reg_byte;
  logic [7:0] wr_byte;
  logic fifo_in_ready;

  // Map a sixteen-byte window offset onto a register target
  function automatic achpd_pkg::achpd_target_t map16(input logic [3:0] a);
    achpd_pkg::achpd_target_t t;
    t = '{valid: 1'b1, ctl: 1'b0, ofs: a[2:0],
          dup: achpd_pkg::DUP_NONE};
    case (a)
      achpd_pkg::IX_DATA_LO: begin
        t.ofs = achpd_pkg::OFS_DATA;
        t.dup = achpd_pkg::DUP_LOW;
      end
      achpd_pkg::IX_DATA_HI: begin
        t.ofs = achpd_pkg::OFS_DATA;
        t.dup = achpd_pkg::DUP_HIGH;
      end
      achpd_pkg::IX_ERR_DUP: t.ofs = achpd_pkg::OFS_ERR_FEAT;
      achpd_pkg::IX_ALT: begin
        t.ctl = 1'b1;
        t.ofs = achpd_pkg::CTL_ALT_DEVCTL;
      end
      achpd_pkg::IX_DRV_ADDR: begin
        t.ctl = 1'b1;
        t.ofs = achpd_pkg::CTL_DRV_ADDR;
      end
      default: t.valid = ~a[3]; // Offsets A-C are invalid
    endcase
    return t;
  endfunction : map16

  // ----------------------------------------------------------------
  // Address and strobe decode
  // ----------------------------------------------------------------
  // Picks the strobes and address bits that the active personality uses
  always_comb begin
    tgt = '{valid: 1'b0, ctl: 1'b0, ofs: 3'h0, dup: achpd_pkg::DUP_NONE};
    rd_now = 1'b0;
    wr_now = 1'b0;
    io_cfg = 1'b0;
    if (st_reg.ide_mode) begin
      rd_now = ~io_read_n;
      wr_now = ~io_write_n;
      if (!even_enable_n && odd_enable_n) begin
        tgt.valid = 1'b1; // Only A0-2 used
        tgt.ofs = addr[2:0];
      end else if (!odd_enable_n && even_enable_n) begin
        tgt.ctl = 1'b1;
        tgt.ofs = addr[2:0];
        tgt.valid = (addr[2:1] == 2'b11);
      end
    end else begin
      case (achpd_pkg::achpd_cfg_t'(pc_config))
        achpd_pkg::CFG_MEMORY: begin
          rd_now = ~out_enable_n;
          wr_now = ~wr_enable_n;
          if (reg_select_n) begin // Common memory plane
            if (addr[achpd_pkg::MEM_DATA_BIT]) begin
              tgt.valid = 1'b1; // Each word address feeds data
            end else if (addr[9:4] == 6'h00) begin
              tgt = map16(addr[3:0]);
            end
          end
        end
        achpd_pkg::CFG_INDEP_IO: begin
          io_cfg = 1'b1;
          rd_now = ~io_read_n;
          wr_now = ~io_write_n;
          if (!reg_select_n) begin
            tgt = map16(addr[3:0]); // Low four bits only
          end
        end
        achpd_pkg::CFG_PRIMARY, achpd_pkg::CFG_SECONDARY: begin
          io_cfg = 1'b1;
          rd_now = ~io_read_n;
          wr_now = ~io_write_n;
          if (!reg_select_n) begin
            if (addr[9:3] == ((pc_config == 2'h2) ?
                achpd_pkg::PRI_CMD_BASE[9:3] :
                achpd_pkg::SEC_CMD_BASE[9:3])) begin
              tgt.valid = 1'b1; // A3-9 compared, A10 ignored
              tgt.ofs = addr[2:0];
            end else if (addr[9:1] == ((pc_config == 2'h2) ?
                achpd_pkg::PRI_CTL_BASE[9:1] :
                achpd_pkg::SEC_CTL_BASE[9:1])) begin
              tgt.valid = 1'b1;
              tgt.ctl = 1'b1;
              tgt.ofs = addr[2:0];
            end
          end
        end
        default: tgt.valid = 1'b0;
      endcase
    end
  end

  // Lane selection and qualified access
  assign enabled = ~even_enable_n | ~odd_enable_n;
  assign access = enabled & tgt.valid & (rd_now ^ wr_now);
  assign data_tgt = ~tgt.ctl & (tgt.ofs == achpd_pkg::OFS_DATA);
  assign lane_lo = st_reg.ide_mode | ~even_enable_n;
  assign lane_hi = st_reg.ide_mode ? data_tgt : ~odd_enable_n;

  // Reset pin polarity follows the personality
  assign pin_rst = st_reg.mode_taken &
    (st_reg.ide_mode ? ~host_reset_pin : host_reset_pin);

  // Ready when initialised, idle and able to buffer a word
  assign rdy = st_reg.init_done & ~ctrl_busy & fifo_in_ready;

  // Byte read back for the 8-bit registers
  always_comb begin
    reg_byte = achpd_pkg::REG_RESET;
    if (tgt.ctl) begin
      if (tgt.ofs == achpd_pkg::CTL_ALT_DEVCTL) begin
        reg_byte = status_in;
      end else begin
        reg_byte = drive_addr_in;
      end
    end else begin
      case (tgt.ofs)
        achpd_pkg::OFS_ERR_FEAT: reg_byte = error_code_in;
        achpd_pkg::OFS_COUNT: reg_byte = st_reg.count;
        achpd_pkg::OFS_SECTOR: reg_byte = st_reg.sector;
        achpd_pkg::OFS_CYL_LO: reg_byte = st_reg.cyl_lo;
        achpd_pkg::OFS_CYL_HI: reg_byte = st_reg.cyl_hi;
        achpd_pkg::OFS_DRV_HEAD: reg_byte = st_reg.drv_head;
        achpd_pkg::OFS_STAT_CMD: reg_byte = status_in;
        default: reg_byte = achpd_pkg::REG_RESET;
      endcase
    end
  end

  // Byte taken from whichever lane carried the write
  assign wr_byte = st_reg.act_lo ? st_reg.act_data[7:0] :
    st_reg.act_data[15:8];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.cmd_pulse = 1'b0;
    st_next.push = st_reg.push & ~fifo_in_ready;
    st_next.pop = 1'b0;
    st_next.stschg = 1'b0;
    // Personality caught after release of reset and during pin reset
    if (!st_reg.mode_taken || pin_rst) begin
      st_next.mode_taken = 1'b1;
      st_next.ide_mode = ~personality_detect_n;
    end
    // Hold the access decode and data while the strobe is low
    st_next.act = access;
    if (access) begin
      st_next.act_wr = wr_now;
      st_next.act_tgt = tgt;
      st_next.act_lo = lane_lo;
      st_next.act_data = data_in;
    end
    // Read data and lane enables while the read strobe is low
    st_next.oe_lo = access & rd_now & lane_lo;
    st_next.oe_hi = access & rd_now & lane_hi;
    if (access && rd_now) begin
      if (data_tgt) begin
        st_next.dout = rd_word;
        if (tgt.dup == achpd_pkg::DUP_HIGH) begin
          st_next.dout = {rd_word[15:8], rd_word[15:8]};
        end
      end else begin
        st_next.dout = {reg_byte, reg_byte};
      end
    end
    // Side effects at the rising edge of the strobe
    if (st_reg.act && !access) begin
      if (st_reg.act_wr) begin // Write captured on strobe rise
        if (st_reg.act_tgt.ctl) begin
          if (st_reg.act_tgt.ofs == achpd_pkg::CTL_ALT_DEVCTL) begin
            st_next.dev_ctrl = wr_byte; // Drive address writes ignored
          end
        end else begin
          case (st_reg.act_tgt.ofs)
            achpd_pkg::OFS_DATA: begin
              if (st_reg.act_tgt.dup == achpd_pkg::DUP_LOW) begin
                st_next.lo_hold = wr_byte;
              end else if (st_reg.act_tgt.dup == achpd_pkg::DUP_HIGH) begin
                st_next.push_word = {wr_byte, st_reg.lo_hold};
                st_next.push = 1'b1;
              end else begin
                st_next.push_word = st_reg.act_data;
                st_next.push = 1'b1;
              end
            end
            achpd_pkg::OFS_ERR_FEAT: st_next.feature = wr_byte;
            achpd_pkg::OFS_COUNT: st_next.count = wr_byte;
            achpd_pkg::OFS_SECTOR: st_next.sector = wr_byte;
            achpd_pkg::OFS_CYL_LO: st_next.cyl_lo = wr_byte;
            achpd_pkg::OFS_CYL_HI: st_next.cyl_hi = wr_byte;
            achpd_pkg::OFS_DRV_HEAD: st_next.drv_head = wr_byte;
            default: begin
              st_next.command = wr_byte;
              st_next.cmd_pulse = 1'b1;
              st_next.irq = 1'b0;
            end
          endcase
        end
      end else if (!st_reg.act_tgt.ctl) begin
        if (st_reg.act_tgt.ofs == achpd_pkg::OFS_DATA) begin
          st_next.pop = rd_valid; // New word on each access
        end else if (st_reg.act_tgt.ofs == achpd_pkg::OFS_STAT_CMD) begin
          st_next.irq = 1'b0; // Status read clears
        end
      end
    end
    // Controller request wins over a clear in the same cycle
    if (ctrl_irq) begin
      st_next.irq = 1'b1;
    end
    // Reset initialisation sequence
    if (!st_reg.init_done) begin
      if (st_reg.init_cnt == IW'(INIT_CYCLES - 1)) begin
        st_next.init_done = 1'b1;
      end else begin
        st_next.init_cnt = st_reg.init_cnt + 1'b1;
      end
    end
    // Change notice on ready or write-protect transitions
    st_next.rdy_prev = rdy;
    st_next.wp_prev = st_reg.init_done;
    st_next.stschg = ~st_reg.ide_mode &
      ((rdy != st_reg.rdy_prev) | (st_reg.init_done != st_reg.wp_prev));
    // Hardware reset through the pin clears every drive register
    if (pin_rst) begin
      st_next = '0;
      st_next.mode_taken = 1'b1;
      st_next.ide_mode = ~personality_detect_n;
      st_next.act_tgt.dup = achpd_pkg::DUP_NONE;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Write data buffer toward the controller
  // ----------------------------------------------------------------
  achpd_fifo #(
    .WIDTH(achpd_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(st_reg.push),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Data lanes come from flip-flops
  assign data_out = st_reg.dout;
  assign data_oe_lo = st_reg.oe_lo;
  assign data_oe_hi = st_reg.oe_hi;

  // Ready/busy, PC-card request, or gated IDE interrupt
  always_comb begin
    if (st_reg.ide_mode) begin
      ready_irq_out = st_reg.irq; // Inverted request form
      ready_irq_oe = ~st_reg.dev_ctrl[achpd_pkg::NIEN_POS] &
        (st_reg.drv_head[achpd_pkg::DRV_POS] == drive_unit);
    end else begin
      ready_irq_out = io_cfg ? ~st_reg.irq : rdy;
      ready_irq_oe = 1'b1;
    end
  end

  // Cycle extension while a data word cannot move
  assign wait_n = ~(~st_reg.ide_mode & access & data_tgt &
    ((rd_now & ~rd_valid) | (wr_now & ~fifo_in_ready)));
  assign inpack_n = ~(~st_reg.ide_mode & io_cfg & access & rd_now);

  // Write-protect low after initialisation, or IDE word indication
  assign word_io_out = st_reg.ide_mode ? 1'b0 : ~st_reg.init_done;
  assign word_io_oe = ~st_reg.ide_mode |
    (access & data_tgt);

  assign status_change_n = ~st_reg.stschg;
  assign drive_active_n = 1'b0;
  assign drive_active_oe = st_reg.ide_mode & st_reg.act;
  assign rd_pop = st_reg.pop;

  // Register values toward the controller
  assign feature_select = st_reg.feature;
  assign transfer_sector_count = st_reg.count;
  assign start_sector_number = st_reg.sector;
  assign cylinder_low_byte = st_reg.cyl_lo;
  assign cylinder_high_byte = st_reg.cyl_hi;
  assign drive_head_select = st_reg.drv_head;
  assign device_control = st_reg.dev_ctrl;
  assign command_issue = st_reg.command;
  assign command_strobe = st_reg.cmd_pulse;
endmodule : achpd_top
`default_nettype wire

// File: testbench/achpd_chk.sv
// Assertion checker of the host port decoder
`timescale 1ns/1ps
`default_nettype none
module achpd_chk #(parameter int INIT_CYCLES = 20) (
  input wire logic clock,
  input wire logic rst,
  input wire logic personality_detect_n,
  input wire logic even_enable_n,
  input wire logic odd_enable_n,
  input wire logic io_read_n,
  input wire logic [10:0] addr,
  input wire logic data_oe_lo,
  input wire logic data_oe_hi,
  input wire logic ready_irq_oe,
  input wire logic inpack_n,
  input wire logic word_io_out,
  input wire logic word_io_oe,
  input wire logic status_change_n,
  input wire logic [7:0] device_control
);
  logic first_q, ide_q;
  logic [7:0] cnt;
  // Strap seen at the first edge; cycles counted since reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_q <= 1'h1;
      ide_q <= 1'h0;
      cnt <= 8'h00;
    end else begin
      first_q <= 1'h0;
      if (first_q) ide_q <= !personality_detect_n;
      if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_lanes_idle: assert property (
    (even_enable_n && odd_enable_n)[*2]
    |-> !(data_oe_lo || data_oe_hi)) else $error("lanes driven when idle");
  chk_irq_float: assert property ((ide_q && device_control[1])[*3]
    |-> !ready_irq_oe) else $error("interrupt driven while disabled");
  chk_pc_drive: assert property (!first_q && !ide_q
    |-> ready_irq_oe) else $error("ready pin floating in card mode");
  chk_wp_low: assert property (!ide_q && cnt == INIT_CYCLES + 3
    |-> !word_io_out) else $error("write protect high after init");
  chk_word_sel: assert property (ide_q && word_io_oe
    |-> addr[2:0] == 3'h0 && !even_enable_n) else $error("bad word flag");
  chk_read_lane: assert property (
    (ide_q && !even_enable_n && odd_enable_n && !io_read_n
    && addr[2:0] == 3'h7)[*2] |-> data_oe_lo && !data_oe_hi)
    else $error("status read not on low lane");
  chk_inpack_read: assert property (!inpack_n |-> !io_read_n)
    else $error("acknowledge without read");
  chk_stschg_pulse: assert property (!status_change_n
    |=> status_change_n) else $error("status change longer than a cycle");
  cover property (!status_change_n);
  cover property (ide_q && word_io_oe);
  cover property (ide_q && device_control[1] && !ready_irq_oe);
endmodule : achpd_chk
bind achpd_top achpd_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clock, .rst,
  .personality_detect_n, .even_enable_n, .odd_enable_n, .io_read_n, .addr,
  .data_oe_lo, .data_oe_hi, .ready_irq_oe, .inpack_n, .word_io_out,
  .word_io_oe, .status_change_n, .device_control);
`default_nettype wire

// File: testbench/achpd_host.sv
// Host bus master model for drive register cycles
`timescale 1ns/1ps
`default_nettype none
module achpd_host (
  input wire logic clock,
  input wire logic [15:0] data_out,
  output logic even_enable_n,
  output logic odd_enable_n,
  output logic io_read_n,
  output logic io_write_n,
  output logic [10:0] addr,
  output logic [15:0] data_in
);
  // Bus idle at time zero
  initial begin
    {even_enable_n, odd_enable_n, io_read_n, io_write_n} = 4'hF;
    addr = 11'h000;
    data_in = 16'h0000;
  end
  // Strobe held two cycles, answer taken at the last held edge
  task automatic acc(input logic ctl, input logic [2:0] a, input logic wr,
    input logic [15:0] d, output logic [15:0] q);
    @(posedge clock);
    even_enable_n <= ctl;
    odd_enable_n <= !ctl;
    addr <= {8'h00, a};
    io_read_n <= wr;
    io_write_n <= !wr;
    data_in <= d;
    repeat (2) @(posedge clock);
    q = data_out;
    {even_enable_n, odd_enable_n, io_read_n, io_write_n} <= 4'hF;
    data_in <= ~d;
    repeat (3) @(posedge clock);
  endtask : acc
endmodule : achpd_host
`default_nettype wire

// File: testbench/test_ata_card_host_port_decode.sv
// Self-checking testbench of the host port decoder
`timescale 1ns/1ps
`default_nettype none
module test_ata_card_host_port_decode;
  logic clock = 1'h0, rst = 1'h1, personality_detect_n = 1'h0;
  logic host_reset_pin = 1'h1, reg_select_n = 1'h1, drive_unit = 1'h0;
  logic ctrl_irq = 1'h0, ctrl_busy = 1'h0, rd_valid = 1'h0, wr_ready = 1'h0;
  logic [7:0] status_in = 8'h50;
  logic [1:0] pc_config = 2'h0;
  logic [15:0] rd_word = 16'hBEEF, q;
  logic even_enable_n, odd_enable_n, io_read_n, io_write_n;
  logic [10:0] addr;
  logic [15:0] data_in, data_out, wr_word;
  logic [7:0] transfer_sector_count, device_control, command_issue;
  logic ready_irq_out, ready_irq_oe, word_io_out, wr_valid;
  int bad_count = 0, n_checks = 0;
  always #50 clock = ~clock;
  achpd_host host (.clock, .data_out, .even_enable_n, .odd_enable_n,
    .io_read_n, .io_write_n, .addr, .data_in);
  achpd_top #(.INIT_CYCLES(4)) dut (.clock, .rst, .personality_detect_n,
    .host_reset_pin, .even_enable_n, .odd_enable_n, .reg_select_n,
    .out_enable_n(1'h1), .wr_enable_n(1'h1), .io_read_n, .io_write_n,
    .addr, .data_in, .data_out, .data_oe_lo(), .data_oe_hi(),
    .ready_irq_out, .ready_irq_oe, .wait_n(), .inpack_n(), .word_io_out,
    .word_io_oe(), .status_change_n(), .drive_active_n(),
    .drive_active_oe(), .pc_config, .drive_unit, .ctrl_irq,
    .ctrl_busy, .error_code_in(8'h00), .status_in, .drive_addr_in(8'h00),
    .rd_word, .rd_valid, .rd_pop(), .wr_word, .wr_valid, .wr_ready,
    .feature_select(), .transfer_sector_count, .start_sector_number(),
    .cylinder_low_byte(), .cylinder_high_byte(), .drive_head_select(),
    .device_control, .command_issue, .command_strobe());
  // Compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Reset with the strap and an idle reset pin for that personality
  task automatic do_reset(input logic strap);
    rst <= 1'h1;
    personality_detect_n <= strap;
    host_reset_pin <= !strap;
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    repeat (2) @(posedge clock);
  endtask : do_reset
  // Byte register on the low lane, then a command write
  task automatic t_reg;
    host.acc(1'h0, 3'h2, 1'h1, 16'hA55A, q);
    chk(16'(transfer_sector_count), 16'h005A);
    host.acc(1'h0, 3'h2, 1'h0, 16'h0000, q);
    chk(16'(q[7:0]), 16'h005A);
    host.acc(1'h0, 3'h7, 1'h1, 16'h00EC, q);
    chk(16'(command_issue), 16'h00EC);
  endtask : t_reg
  // Interrupt raised, cleared by a status read, then masked
  task automatic t_irq;
    ctrl_irq <= 1'h1;
    @(posedge clock);
    ctrl_irq <= 1'h0;
    repeat (3) @(posedge clock);
    chk(16'(ready_irq_out & ready_irq_oe), 16'h0001);
    host.acc(1'h0, 3'h7, 1'h0, 16'h0000, q);
    chk(16'(q[7:0]), 16'h0050);
    chk(16'(ready_irq_out), 16'h0000);
    host.acc(1'h1, 3'h6, 1'h1, 16'h0002, q);
    chk(16'(device_control), 16'h0002);
    chk(16'(ready_irq_oe), 16'h0000);
  endtask : t_irq
  // Word read from the controller, word write through the buffer
  task automatic t_data;
    rd_valid <= 1'h1;
    host.acc(1'h0, 3'h0, 1'h0, 16'h0000, q);
    rd_valid <= 1'h0;
    chk(q, 16'hBEEF);
    host.acc(1'h0, 3'h0, 1'h1, 16'h1234, q);
    chk(wr_word, 16'h1234);
    wr_ready <= 1'h1;
    repeat (2) @(posedge clock);
    chk(16'(wr_valid), 16'h0000);
  endtask : t_data
  // Card personality: pin 16 driven and ready, write protect low
  task automatic t_pc;
    do_reset(1'h1);
    repeat (6) @(posedge clock);
    chk(16'(word_io_out), 16'h0000);
    chk(16'(ready_irq_oe & ready_irq_out), 16'h0001);
  endtask : t_pc
  // Main sequence
  initial begin
    do_reset(1'h0);
    t_reg();
    t_irq();
    t_data();
    t_pc();
    give_verdict();
  end
  // Watchdog well past the run length
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
endmodule : test_ata_card_host_port_decode
`default_nettype wire
